// file: hw/fuse_config_and_mode_control.sv
// Fuse bank decoder and operating mode controller of a pixel network node.
`default_nettype none
module fuse_config_and_mode_control
    import fuse_mode_pkg::*;
#(
    parameter int TIMER_CYCLES = CFG_TIMER_CYC
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic [26:0]       fuse_bits,
    input  wire logic              zap_req,
    input  wire logic [26:0]       zap_mask,
    input  wire logic              addr_divider_valid,
    input  wire logic [4:0]        assigned_addr,
    input  wire logic              rx_pin,
    input  wire logic              frame_start,
    input  wire logic              auto_address_enable_frame,
    input  wire logic              auto_addr_done,
    input  wire logic              switch_to_normal_frame,
    input  wire logic              fuse_read_request_frame,
    input  wire logic              fuse_read_data_frame,
    input  wire logic              map_enable_trigger_frame,
    input  wire logic              pwm_mode,
    input  wire logic [11:0]       pwm_switches,
    input  wire logic              direct_wr,
    input  wire logic [11:0]       direct_data,
    input  wire logic              timeout_err,
    input  wire logic              dimming_fault_flag,
    input  wire logic              fault_flags_cleared,
    input  wire logic              thermal_shutdown_flag,
    input  wire logic              pump_undervoltage_flag,
    input  wire logic              supply_low_flag,
    input  wire logic              status_read,
    input  wire logic              echo_missing,
    input  wire logic              read_other_node,
    input  wire logic              read_absent_node,
    input  wire logic              global_err_clear,
    input  wire logic              eeprom_wr_req,
    output logic [3:0]             mode_state,
    output logic                   crc_invalid,
    output logic [4:0]             node_addr,
    output logic                   addr_fused,
    output logic                   network_role_select,
    output logic [1:0]             link_rate_select,
    output logic                   echo_check_en,
    output logic                   uart_en,
    output logic                   mlvds_en,
    output logic [11:0]            switch_state,
    output logic                   zap_strobe,
    output logic [26:0]            zap_bits,
    output logic                   zap_refused,
    output logic                   fuse_rd_valid,
    output logic [26:0]            fuse_rd_word,
    output logic                   global_comm_error_flag,
    output logic                   tx_halt,
    output logic                   link_blocked,
    output logic                   eeprom_wr_grant,
    output logic                   eeprom_wr_refused
);
    localparam int TW = $clog2(TIMER_CYCLES + 1);
    localparam logic [TW-1:0] TMR_LAST = TW'(TIMER_CYCLES - 1);

    if (TIMER_CYCLES < 1) begin : g_chk
        $error("TIMER_CYCLES must be at least one");
    end

    typedef struct packed {
        mode_type    mode;
        logic        fs_ret;
        logic [26:0] bank;
        logic        crc_ok;
        logic        crc_bad;
        logic        prog;
        logic [TW-1:0] tmr;
        logic        tmr_run;
        logic        uart_pick;
        logic        map_armed;
        logic [11:0] sw;
        logic        rd_pend;
        logic        rd_valid;
        logic [26:0] rd_buf;
        logic        zap_stb;
        logic        zap_rej;
        logic [26:0] zap;
        logic        role;
        logic [1:0]  rate;
        logic        echo_en;
        logic        uart_en;
        logic        mlvds_en;
        logic [4:0]  addr;
        logic        addr_fused;
        logic        ee_grant;
        logic        ee_refuse;
        logic        gerr;
        logic        halt;
        logic        blocked;
        logic [2:0]  rx_s;
        logic        rx_lvl;
    } state_type;

    state_type s_r;
    state_type s_nxt;
    logic [11:0] safe_sw;
    logic        sv;
    logic        norm;
    logic [26:0] zap_ok;

    function automatic logic [6:0] fuse_crc(input logic [19:0] d);
        logic [6:0] c;
        logic       fb;
        c = CRC_SEED;
        for (int i = 19; i >= 0; i--) begin
            fb = c[6] ^ d[i];
            c = {c[5:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

    for (genvar k = 0; k < SW_N; k++) begin : g_safe
        assign safe_sw[k] = s_r.bank[BIT_SAFE_LO + k / 3];
    end

    always_comb begin
        zap_ok = zap_mask;
        if (fuse_bits[BIT_BANK_LK]) begin
            zap_ok = '0;
        end
        if (fuse_bits[BIT_ADDR_LK]) begin
            zap_ok = zap_ok & ~ADDR_FIELD;
        end
        if (fuse_bits[BIT_SAFE_LK]) begin
            zap_ok = zap_ok & ~SAFE_FIELD;
        end
        if (fuse_bits[BIT_NET_LK]) begin
            zap_ok = zap_ok & ~NET_FIELD;
        end
    end

    assign norm = (s_r.mode == ST_NORMAL) || (s_r.mode == ST_NO_CRC);

    always_comb begin
        s_nxt = s_r;
        s_nxt.zap_stb = 1'b0;
        s_nxt.zap_rej = 1'b0;
        s_nxt.rd_valid = 1'b0;
        s_nxt.ee_grant = 1'b0;
        s_nxt.ee_refuse = 1'b0;
        // The first stage feeds only the second; two later stages vote.
        s_nxt.rx_s = {s_r.rx_s[1:0], rx_pin};
        if (s_r.rx_s[1] == s_r.rx_s[2]) begin
            s_nxt.rx_lvl = s_r.rx_s[2];
        end
        case (s_r.mode)
            ST_LOAD: begin
                s_nxt.bank = fuse_bits;
                s_nxt.mode = ST_CHECK;
            end
            ST_CHECK: begin
                s_nxt.crc_ok = fuse_crc(s_r.bank[19:0])
                    == s_r.bank[BIT_CRC_HI:BIT_CRC_LO];
                s_nxt.prog = |s_r.bank;
                if (s_nxt.prog && s_nxt.crc_ok) begin
                    s_nxt.mode = ST_NORMAL;
                end else if (s_nxt.prog) begin
                    s_nxt.mode = ST_CONFIG;
                end else begin
                    s_nxt.mode = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (addr_divider_valid) begin
                    s_nxt.mode = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (zap_req && (zap_ok != '0)) begin
                    s_nxt.zap_stb = 1'b1;
                    s_nxt.zap = zap_ok;
                end else if (zap_req) begin
                    s_nxt.zap_rej = 1'b1;
                end
                if (auto_address_enable_frame) begin
                    s_nxt.mode = ST_AUTO;
                end else if (switch_to_normal_frame) begin
                    s_nxt.mode = ST_NO_CRC;
                end
            end
            ST_AUTO: begin
                if (auto_addr_done) begin
                    s_nxt.mode = ST_CONFIG;
                end
            end
            ST_NORMAL, ST_NO_CRC: begin
                if (thermal_shutdown_flag || pump_undervoltage_flag
                        || supply_low_flag) begin
                    s_nxt.fs_ret = (s_r.mode == ST_NO_CRC);
                    s_nxt.mode = ST_FS_OPEN;
                end else if (timeout_err || dimming_fault_flag) begin
                    s_nxt.fs_ret = (s_r.mode == ST_NO_CRC);
                    s_nxt.mode = ST_FS_OTP;
                end
            end
            ST_FS_OTP: begin
                if (thermal_shutdown_flag || pump_undervoltage_flag
                        || supply_low_flag) begin
                    s_nxt.mode = ST_FS_OPEN;
                end else if (fault_flags_cleared) begin
                    s_nxt.mode = s_r.fs_ret ? ST_NO_CRC : ST_NORMAL;
                end
            end
            ST_FS_OPEN: begin
                if (status_read) begin
                    s_nxt.mode = s_r.fs_ret ? ST_NO_CRC : ST_NORMAL;
                end
            end
            default: s_nxt.mode = ST_LOAD;
        endcase
        if (s_r.mode == ST_CHECK && !s_nxt.prog) begin
            s_nxt.tmr_run = 1'b1;
            s_nxt.tmr = '0;
        end else if (s_r.mode == ST_CONFIG && s_r.tmr_run) begin
            s_nxt.tmr = s_r.tmr + 1'b1;
            if (s_r.tmr == TMR_LAST) begin
                s_nxt.tmr_run = 1'b0;
                s_nxt.uart_pick = s_r.rx_lvl;
            end
        end
        if (s_nxt.mode != ST_CONFIG && s_r.mode == ST_CONFIG) begin
            s_nxt.tmr_run = 1'b0;
        end
        if (s_nxt.mode == ST_NORMAL || s_nxt.mode == ST_NO_CRC) begin
            if (map_enable_trigger_frame) begin
                s_nxt.map_armed = 1'b1;
            end
            if (!pwm_mode && direct_wr) begin
                s_nxt.sw = direct_data;
            end else if (pwm_mode && s_nxt.map_armed) begin
                s_nxt.sw = pwm_switches;
            end
            if (!norm && s_r.mode != ST_FS_OTP && s_r.mode != ST_FS_OPEN
                    && s_r.bank[BIT_SAFE_LK]) begin
                s_nxt.sw = safe_sw;
            end
        end else if (s_nxt.mode == ST_FS_OTP) begin
            if (s_r.bank[BIT_SAFE_LK]) begin
                s_nxt.sw = safe_sw;
            end
        end else begin
            s_nxt.sw = '0;
        end
        if (fuse_read_request_frame) begin
            s_nxt.rd_pend = 1'b1;
            s_nxt.rd_buf = fuse_bits;
        end else if (fuse_read_data_frame && s_r.rd_pend) begin
            s_nxt.rd_pend = 1'b0;
            s_nxt.rd_valid = 1'b1;
        end
        if (eeprom_wr_req) begin
            s_nxt.ee_refuse = s_nxt.bank[BIT_EE_WP];
            s_nxt.ee_grant = !s_nxt.bank[BIT_EE_WP];
        end
        sv = s_nxt.bank[BIT_NET_LK] && s_nxt.crc_ok;
        s_nxt.crc_bad = !s_nxt.crc_ok;
        s_nxt.addr_fused = s_nxt.bank[BIT_ADDR_LK];
        s_nxt.addr = s_nxt.addr_fused
            ? s_nxt.bank[BIT_ADDR_HI:BIT_ADDR_LO] : assigned_addr;
        s_nxt.role = sv && s_nxt.bank[BIT_ROLE];
        s_nxt.rate = sv ? s_nxt.bank[BIT_RATE_HI:BIT_RATE_LO]
                        : RATE_DEFAULT;
        s_nxt.echo_en = !(sv && s_nxt.bank[BIT_ECHO_DIS]);
        s_nxt.mlvds_en = !(sv && s_nxt.bank[BIT_MLVDS_DIS]);
        s_nxt.uart_en = sv ? !s_nxt.bank[BIT_UART_DIS] : s_nxt.uart_pick;
        if (echo_missing && s_r.echo_en) begin
            s_nxt.halt = 1'b1;
        end else if (frame_start) begin
            s_nxt.halt = 1'b0;
        end
        if (s_r.role && read_other_node) begin
            s_nxt.gerr = 1'b1;
        end else if (global_err_clear) begin
            s_nxt.gerr = 1'b0;
        end
        // lockup only cleared by power cycle
        if (s_r.role && !s_r.echo_en && read_absent_node) begin
            s_nxt.blocked = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_r <= '0;
            s_r.mode <= ST_LOAD;
            s_r.crc_bad <= 1'b1;
            s_r.uart_pick <= 1'b1;
            s_r.uart_en <= 1'b1;
            s_r.mlvds_en <= 1'b1;
            s_r.echo_en <= 1'b1;
            s_r.rate <= RATE_DEFAULT;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign mode_state = s_r.mode;
    assign crc_invalid = s_r.crc_bad;
    assign node_addr = s_r.addr;
    assign addr_fused = s_r.addr_fused;
    assign network_role_select = s_r.role;
    assign link_rate_select = s_r.rate;
    assign echo_check_en = s_r.echo_en;
    assign uart_en = s_r.uart_en;
    assign mlvds_en = s_r.mlvds_en;
    assign switch_state = s_r.sw;
    assign zap_strobe = s_r.zap_stb;
    assign zap_bits = s_r.zap;
    assign zap_refused = s_r.zap_rej;
    assign fuse_rd_valid = s_r.rd_valid;
    assign fuse_rd_word = s_r.rd_buf;
    assign global_comm_error_flag = s_r.gerr;
    assign tx_halt = s_r.halt;
    assign link_blocked = s_r.blocked;
    assign eeprom_wr_grant = s_r.ee_grant;
    assign eeprom_wr_refused = s_r.ee_refuse;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst || !clk_en);

    bank_lock_zap_a: assert property (
        zap_strobe |-> !$past(fuse_bits[BIT_BANK_LK]))
        else $error("zap issued with bank lock set");
    zap_mode_a: assert property (
        zap_strobe |-> $past(s_r.mode) == ST_CONFIG)
        else $error("zap outside configuration mode");
    addr_lock_zap_a: assert property (
        zap_strobe && $past(fuse_bits[BIT_ADDR_LK]) |-> zap_bits[6:2] == '0)
        else $error("address bits zapped under lock");
    safe_lock_zap_a: assert property (
        zap_strobe && $past(fuse_bits[BIT_SAFE_LK]) |-> zap_bits[11:8] == '0)
        else $error("string bits zapped under lock");
    rate_default_a: assert property (
        s_r.mode != ST_LOAD && !(s_r.bank[BIT_NET_LK] && s_r.crc_ok)
        |-> link_rate_select == RATE_DEFAULT && !network_role_select)
        else $error("unvalidated rate or role used");
    open_on_fault_a: assert property (
        norm && thermal_shutdown_flag |=> mode_state == ST_FS_OPEN
        ##0 switch_state == '0)
        else $error("switches not opened on fault");
    bad_crc_cfg_a: assert property (
        s_r.mode == ST_CHECK && (|s_r.bank)
        && fuse_crc(s_r.bank[19:0]) != s_r.bank[26:20]
        |=> mode_state == ST_CONFIG ##1 crc_invalid)
        else $error("bad checksum did not enter configuration");
    fuse_read_a: assert property (
        fuse_rd_valid |-> $past(fuse_read_data_frame)
        && !$past(fuse_read_request_frame))
        else $error("fuse data returned without data frame");
    global_err_a: assert property (
        network_role_select && read_other_node |=> global_comm_error_flag)
        else $error("global error not flagged");
    blocked_hold_a: assert property (
        link_blocked |=> link_blocked)
        else $error("lockup released without power cycle");
    eeprom_wp_a: assert property (
        eeprom_wr_req && s_r.bank[BIT_EE_WP]
        |=> eeprom_wr_refused && !eeprom_wr_grant)
        else $error("protected EEPROM write granted");

    normal_entry_c: cover property (s_r.mode == ST_CHECK
        ##1 mode_state == ST_NORMAL);
    fs_open_c: cover property (mode_state == ST_FS_OPEN
        ##[1:20] mode_state == ST_NORMAL);
    auto_addr_c: cover property (mode_state == ST_AUTO
        ##[1:20] mode_state == ST_CONFIG);
    fuse_read_c: cover property (fuse_rd_valid);
endmodule // fuse_config_and_mode_control
`default_nettype wire

// file: hw/fuse_mode_pkg.sv
// Constants for the fuse bank decoder and operating mode controller.
`default_nettype none
package fuse_mode_pkg;
    localparam int FUSE_W       = 27;
    localparam int SW_N         = 12;
    localparam int STR_N        = 4;
    localparam int BIT_BANK_LK  = 0;
    localparam int BIT_ADDR_LK  = 1;
    localparam int BIT_ADDR_LO  = 2;
    localparam int BIT_ADDR_HI  = 6;
    localparam int BIT_SAFE_LK  = 7;
    localparam int BIT_SAFE_LO  = 8;
    localparam int BIT_SAFE_HI  = 11;
    localparam int BIT_NET_LK   = 12;
    localparam int BIT_ROLE     = 13;
    localparam int BIT_RATE_LO  = 14;
    localparam int BIT_RATE_HI  = 15;
    localparam int BIT_ECHO_DIS = 16;
    localparam int BIT_MLVDS_DIS = 17;
    localparam int BIT_UART_DIS = 18;
    localparam int BIT_EE_WP    = 19;
    localparam int BIT_CRC_LO   = 20;
    localparam int BIT_CRC_HI   = 26;
    // Bits each lock protects, besides the general bank lock.
    localparam logic [26:0] ADDR_FIELD = 27'h000007c;
    localparam logic [26:0] SAFE_FIELD = 27'h0000f00;
    localparam logic [26:0] NET_FIELD  = 27'h007e000;
    // Koopman 0x5b is x^7+x^5+x^4+x^2+x+1; the x^7 term is implicit.
    localparam logic [6:0]  CRC_POLY   = 7'h37;
    localparam logic [6:0]  CRC_SEED   = 7'h7f;
    // Link rate codes: 125, 250, 500 and 1000 kb/s.
    localparam logic [1:0]  RATE_125   = 2'h0;
    localparam logic [1:0]  RATE_250   = 2'h1;
    localparam logic [1:0]  RATE_500   = 2'h2;
    localparam logic [1:0]  RATE_1000  = 2'h3;
    localparam logic [1:0]  RATE_DEFAULT = RATE_250;
    localparam int CLK_MHZ       = 100;
    localparam int CFG_TIMER_MS  = 60;
    localparam int CFG_TIMER_CYC = CFG_TIMER_MS * 1000 * CLK_MHZ;
    typedef enum logic [3:0] {
        ST_LOAD    = 4'h0,
        ST_CHECK   = 4'h1,
        ST_WAIT    = 4'h2,
        ST_CONFIG  = 4'h3,
        ST_AUTO    = 4'h4,
        ST_NORMAL  = 4'h5,
        ST_NO_CRC  = 4'h6,
        ST_FS_OTP  = 4'h7,
        ST_FS_OPEN = 4'h8
    } mode_type;
endpackage
`default_nettype wire

// file: tb/fuse_host_model.sv
// Host side model: sends configuration frames and holds the RX line.
`default_nettype none
module fuse_host_model (
    input  wire logic       mclk,
    output logic      [5:0] frames,
    output logic            rx_level
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frames   = 6'h00;
        rx_level = 1'b1;
    end
    task automatic set_rx(input logic v);
        rx_level = v;
    endtask
    // One frame is one pulse; the gap lets the node act before the next.
    task automatic frame(input int idx);
        @(negedge mclk);
        frames[idx] = 1'b1;
        @(negedge mclk);
        frames[idx] = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic read_fuse();
        frame(3);
        frame(4);
    endtask
endmodule // fuse_host_model
`default_nettype wire

// file: tb/fuse_config_and_mode_control_tb_top.sv
// Self-checking bench for the fuse decoder and mode controller.
`default_nettype none
module fuse_config_and_mode_control_tb_top import fuse_mode_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] BASE = 20'haf5d6;
    localparam logic [26:0] LOCKS [4] = '{27'h2, 27'h80, 27'h1000, 27'h1};
    localparam logic [26:0] MASKS [4] = '{27'h7c, 27'hf00, 27'h7e000,
                                          27'h7ffffff};
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [26:0] fuse_bits = 27'h0;
    logic [26:0] zap_mask = 27'h0;
    logic [11:0] p = 12'h000;
    logic [2:0]  lv = 3'h0;
    logic [11:0] direct_data = 12'h000;
    logic        ce = 1'b1;
    logic        adv = 1'b0;
    logic        pm = 1'b0;
    logic [11:0] psw = 12'h000;
    logic [4:0]  aa = 5'h0b;
    logic [5:0]  fr;
    logic        rx;
    logic [3:0]  mode_state;
    logic        crc_invalid, addr_fused, network_role_select;
    logic [4:0]  node_addr;
    logic [1:0]  link_rate_select;
    logic        echo_check_en, uart_en, mlvds_en;
    logic [11:0] switch_state;
    logic        zap_strobe, zap_refused, fuse_rd_valid;
    logic [26:0] zap_bits, fuse_rd_word, good, bad, quiet;
    logic        global_comm_error_flag, tx_halt, link_blocked;
    logic        eeprom_wr_grant, eeprom_wr_refused;
    logic [4:0]  seen = 5'h00;
    int          bad_count = 0;
    int          n_compared = 0;

    always #5 mclk = ~mclk;

    // Short answer pulses are caught here so a check can look later.
    always @(posedge mclk) begin
        seen <= seen | {zap_strobe, zap_refused, fuse_rd_valid,
                        eeprom_wr_grant, eeprom_wr_refused};
    end

    fuse_host_model i_host (.mclk, .frames(fr), .rx_level(rx));

    fuse_config_and_mode_control #(.TIMER_CYCLES(20)) i_dut (
        .mclk, .srst, .fuse_bits, .zap_mask, .direct_data,
        .clk_en(ce), .addr_divider_valid(adv), .assigned_addr(aa),
        .pwm_mode(pm), .pwm_switches(psw), .rx_pin(rx),
        .zap_req(p[0]), .auto_addr_done(p[1]), .direct_wr(p[2]),
        .timeout_err(p[3]), .dimming_fault_flag(p[4]),
        .fault_flags_cleared(p[5]), .status_read(p[6]),
        .echo_missing(p[7]), .read_other_node(p[8]),
        .read_absent_node(p[9]), .global_err_clear(p[10]),
        .eeprom_wr_req(p[11]), .frame_start(fr[0]),
        .auto_address_enable_frame(fr[1]), .switch_to_normal_frame(fr[2]),
        .fuse_read_request_frame(fr[3]), .fuse_read_data_frame(fr[4]),
        .map_enable_trigger_frame(fr[5]), .thermal_shutdown_flag(lv[0]),
        .pump_undervoltage_flag(lv[1]), .supply_low_flag(lv[2]),
        .mode_state, .crc_invalid, .node_addr, .addr_fused,
        .network_role_select, .link_rate_select, .echo_check_en, .uart_en,
        .mlvds_en, .switch_state, .zap_strobe, .zap_bits, .zap_refused,
        .fuse_rd_valid, .fuse_rd_word, .global_comm_error_flag, .tx_halt,
        .link_blocked, .eeprom_wr_grant, .eeprom_wr_refused
    );

    function automatic logic [6:0] crc7(input logic [19:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h7f;
        for (int i = 19; i >= 0; i--) begin
            fb = c[6] ^ d[i];
            c  = {c[5:0], 1'b0} ^ (fb ? 7'h37 : 7'h00);
        end
        return c;
    endfunction

    task automatic chk(input string what, input logic [26:0] exp,
                       input logic [26:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pulse(input int idx);
        @(negedge mclk);
        seen = 5'h00;
        p[idx] = 1'b1;
        @(negedge mclk);
        p[idx] = 1'b0;
        repeat (3) @(negedge mclk);
    endtask

    task automatic rst(input logic [26:0] bank);
        @(negedge mclk);
        fuse_bits = bank;
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
    endtask

    task automatic results();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        results();
    end

    initial begin
        good = {crc7(BASE), BASE};
        bad  = good ^ 27'h4000000;
        // Same bank with echo checking fused off, to reach the lockup path.
        quiet = {crc7(BASE | 20'h10000), BASE | 20'h10000};
        i_host.set_rx(1'b0);
        rst(27'h0);
        chk("mode", ST_WAIT, mode_state);
        adv = 1'b1;
        repeat (2) @(negedge mclk);
        chk("mode", ST_CONFIG, mode_state);
        chk("crc_invalid", 1'b1, crc_invalid);
        chk("rate", RATE_250, link_rate_select);
        chk("uart_en", 1'b1, uart_en);
        chk("node_addr", 5'h0b, node_addr);
        chk("addr_fused", 1'b0, addr_fused);
        repeat (30) @(negedge mclk);
        chk("uart_en", 1'b0, uart_en);
        pulse(11);
        chk("eeprom", 5'h02, seen);
        for (int i = 0; i < 4; i++) begin
            fuse_bits = LOCKS[i];
            zap_mask  = MASKS[i];
            pulse(0);
            chk("zap", 5'h08, seen);
        end
        fuse_bits = 27'h2;
        zap_mask  = 27'h17c;
        pulse(0);
        chk("zap", 5'h10, seen);
        chk("zap_bits", 27'h100, zap_bits);
        fuse_bits = 27'h5a5a5a5;
        seen = 5'h00;
        i_host.read_fuse();
        chk("rd_valid", 5'h04, seen);
        chk("rd_word", 27'h5a5a5a5, fuse_rd_word);
        i_host.frame(1);
        chk("mode", ST_AUTO, mode_state);
        pulse(1);
        chk("mode", ST_CONFIG, mode_state);
        i_host.frame(2);
        chk("mode", ST_NO_CRC, mode_state);
        chk("crc_invalid", 1'b1, crc_invalid);
        fuse_bits = 27'h0;
        pulse(0);
        chk("zap", 5'h00, seen);
        i_host.set_rx(1'b1);
        rst(bad);
        chk("mode", ST_CONFIG, mode_state);
        chk("role", 1'b0, network_role_select);
        chk("rate", RATE_250, link_rate_select);
        chk("mlvds_en", 1'b1, mlvds_en);
        rst(good);
        chk("mode", ST_NORMAL, mode_state);
        chk("crc_invalid", 1'b0, crc_invalid);
        chk("role", 1'b1, network_role_select);
        chk("rate", RATE_1000, link_rate_select);
        chk("mlvds_en", 1'b0, mlvds_en);
        chk("uart_en", 1'b1, uart_en);
        chk("echo_en", 1'b1, echo_check_en);
        chk("node_addr", 5'h15, node_addr);
        chk("addr_fused", 1'b1, addr_fused);
        chk("sw", 12'h1c7, switch_state);
        pulse(11);
        chk("eeprom", 5'h01, seen);
        direct_data = 12'habc;
        pulse(2);
        chk("sw", 12'habc, switch_state);
        // A write while the enable is low must leave every state alone.
        ce = 1'b0;
        direct_data = 12'h123;
        pulse(2);
        chk("sw", 12'habc, switch_state);
        ce = 1'b1;
        pm = 1'b1;
        psw = 12'h5a5;
        repeat (3) @(negedge mclk);
        chk("sw", 12'habc, switch_state);
        i_host.frame(5);
        chk("sw", 12'h5a5, switch_state);
        pm = 1'b0;
        for (int i = 0; i < 3; i++) begin
            lv[i] = 1'b1;
            repeat (3) @(negedge mclk);
            chk("mode", ST_FS_OPEN, mode_state);
            chk("sw", 12'h000, switch_state);
            lv[i] = 1'b0;
            pulse(6);
            chk("mode", ST_NORMAL, mode_state);
        end
        for (int i = 3; i < 5; i++) begin
            pulse(i);
            chk("mode", ST_FS_OTP, mode_state);
            chk("sw", 12'h1c7, switch_state);
            pulse(5);
            chk("mode", ST_NORMAL, mode_state);
        end
        pulse(8);
        chk("gflag", 1'b1, global_comm_error_flag);
        pulse(10);
        chk("gflag", 1'b0, global_comm_error_flag);
        pulse(7);
        chk("tx_halt", 1'b1, tx_halt);
        i_host.frame(0);
        chk("tx_halt", 1'b0, tx_halt);
        pulse(9);
        chk("blocked", 1'b0, link_blocked);
        rst(quiet);
        chk("echo_en", 1'b0, echo_check_en);
        pulse(7);
        chk("tx_halt", 1'b0, tx_halt);
        pulse(9);
        i_host.frame(0);
        chk("blocked", 1'b1, link_blocked);
        results();
    end
endmodule // fuse_config_and_mode_control_tb_top
`default_nettype wire
